// file: dv/csf_host_model.sv
// Host side of the status pins: state pin pull-up, interrupt timing
`timescale 1ns/1ns
`default_nettype none
module csf_host_model (
  input wire logic core_clk, // Clock
  input wire logic stat_oe, // Device pulls pin low
  input wire logic host_int_n, // Interrupt line
  output logic stat_pin, // Resolved pin level
  output logic [15:0] int_len // Width of last low pulse
);
  logic [15:0] cnt_r; // Running low count
  assign stat_pin = stat_oe ? 1'b0 : 1'b1;
  always_ff @(posedge core_clk) begin
    cnt_r <= host_int_n ? 16'h0 : cnt_r + 16'h1;
    if (host_int_n && cnt_r != 16'h0) int_len <= cnt_r;
  end
endmodule
`default_nettype wire

// file: dv/test_csf_core.sv
// Directed bench for the charge supervision fault logic
`timescale 1ns/1ns
`default_nettype none
module test_csf_core;
  import csf_pkg::*;
  logic core_clk = 1'b0; // Clock
  logic arst_n = 1'b0; // Reset
  logic [5:0] adr = 6'h0; // Address
  logic rd = 1'b0; // Read
  logic wr = 1'b0; // Write
  logic [31:0] wd = 32'h0; // Write data
  logic [31:0] rdata; // Read data
  logic wait_r; // Stall
  csf_pin_t p = 17'h00007; // Pins, input good, charge on
  csf_pwr_t pwr; // Power controls
  logic good_n, stat_oe, int_n, stat_pin; // Status lines
  logic [1:0] tls; // Thermal limit select
  logic stat_lvl; // State pin drive level
  logic [15:0] int_len; // Pulse width
  logic [7:0] q; // Last read
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  csf_core #(.HALF_SEC(4), .INT_CYC(8)) dut (.core_clk(core_clk),
    .arst_n(arst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .pins_i(p), .pwr_o(pwr),
    .thermal_limit_sel(tls), .input_good_pin_n(good_n), .stat_o(stat_lvl),
    .stat_oe(stat_oe), .host_int_n(int_n));
  csf_host_model host (.core_clk(core_clk), .stat_oe(stat_oe),
    .host_int_n(int_n), .stat_pin(stat_pin), .int_len(int_len));
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    @(posedge core_clk);
    while (wait_r !== 1'b0) @(posedge core_clk);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #25 core_clk = ~core_clk;
  // Hang guard; the two long timer runs need about 51,000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(1'b0, OFS_FLT, 8'h0);
    chk("fault_latch", 8'h80, q);
    chk("thermal_limit_sel", {6'h0, RST_THR[1:0]}, {6'h0, tls});
    chk("stat_o", 8'h0, {7'h0, stat_lvl});
    bus(1'b0, OFS_TRM, 8'h0);
    chk("term_timer_control", RST_TRM, q);
    p.input_overvoltage <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("buck_run", 8'h0, {7'h0, pwr.buck_run});
    chk("input_good_pin_n", 8'h1, {7'h0, good_n});
    p.input_overvoltage <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk("int_len", 8'h8, int_len[7:0]);
    bus(1'b0, OFS_FLT, 8'h0);
    chk("fault_latch", 8'h90, q);
    bus(1'b0, OFS_FLT, 8'h0);
    chk("fault_latch", 8'h80, q);
    chk("input_good_pin_n", 8'h0, {7'h0, good_n});
    chk("stat_pin", 8'h0, {7'h0, stat_pin});
    // Default-mode charging from a 100 mA port ends in highz
    p.usb100 <= 1'b1;
    repeat (21700) @(posedge core_clk);
    bus(1'b0, OFS_SRC, 8'h0);
    chk("input_source_control", RST_SRC | 8'h80, q);
    chk("buck_run", 8'h0, {7'h0, pwr.buck_run});
    p.usb100 <= 1'b0;
    bus(1'b1, OFS_SRC, RST_SRC);
    repeat (4) @(posedge core_clk);
    chk("buck_run", 8'h1, {7'h0, pwr.buck_run});
    // Full battery with termination off stays in fast charge
    bus(1'b1, OFS_TRM, 8'h1a);
    p.bat_above_rechg <= 1'b1;
    p.ichg_below_term <= 1'b1;
    repeat (20) @(posedge core_clk);
    bus(1'b0, OFS_STS, 8'h0);
    chk("phase", {2'h0, PH_FAST, 4'h0}, q & 8'h30);
    bus(1'b1, OFS_TRM, RST_TRM);
    repeat (20) @(posedge core_clk);
    bus(1'b0, OFS_STS, 8'h0);
    chk("phase", {2'h0, PH_DONE, 4'h0}, q & 8'h30);
    chk("switch", 8'h0, {7'h0, pwr.battery_path_switch});
    chk("stat_pin", 8'h1, {7'h0, stat_pin});
    bus(1'b0, OFS_FLT, 8'h0);
    chk("fault_latch", 8'h00, q);
    // Reduced charge: host turns termination off and stops charging
    bus(1'b1, OFS_CUR, RST_CUR | 8'h01);
    bus(1'b1, OFS_TRM, 8'h1a);
    bus(1'b1, OFS_PWR, 8'h0b);
    repeat (10) @(posedge core_clk);
    bus(1'b0, OFS_STS, 8'h0);
    chk("phase", {2'h0, PH_OFF, 4'h0}, q & 8'h30);
    chk("stat_pin", 8'h1, {7'h0, stat_pin});
    // Low-battery expiry in host mode; timer reprogrammed while off
    bus(1'b1, OFS_CUR, RST_CUR);
    bus(1'b1, OFS_TRM, 8'h12);
    bus(1'b1, OFS_TRM, 8'h10);
    p.bat_low <= 1'b1;
    p.bat_above_rechg <= 1'b0;
    bus(1'b1, OFS_TRM, 8'h18);
    bus(1'b1, OFS_PWR, RST_PWR);
    repeat (29000) @(posedge core_clk);
    bus(1'b0, OFS_FLT, 8'h0);
    chk("fault_latch", {2'h0, FC_TIMER, 4'h0}, q);
    bus(1'b0, OFS_FLT, 8'h0);
    chk("fault_latch", {2'h0, FC_TIMER, 4'h0}, q);
    bus(1'b0, OFS_SRC, 8'h0);
    chk("input_source_control", RST_SRC, q);
    chk("buck_run", 8'h1, {7'h0, pwr.buck_run});
    // Boost overvoltage trips boost and is latched
    p.boost_mode <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("boost_run", 8'h1, {7'h0, pwr.boost_run});
    p.boost_ov <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("boost_run", 8'h0, {7'h0, pwr.boost_run});
    bus(1'b0, OFS_FLT, 8'h0);
    chk("fault_latch", {2'h1, FC_TIMER, 4'h0}, q);
    print_verdict();
  end
endmodule
`default_nettype wire

// file: hdl/csf_core.sv
// Charge termination, safety timers, status pins and fault latch
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module csf_core
  import csf_pkg::*;
#(
  parameter int HALF_SEC = csf_pkg::HALF_SEC_CYC, // Cycles per 0.5 s
  parameter int INT_CYC = csf_pkg::INT_PULSE_CYC // Interrupt width
) (
  input wire logic core_clk, // 20 MHz clock
  input wire logic arst_n, // Async reset, low active
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire csf_pkg::csf_pin_t pins_i, // Asynchronous inputs
  output csf_pkg::csf_pwr_t pwr_o, // Power stage controls
  output logic [1:0] thermal_limit_sel, // Thermal limit select
  output logic input_good_pin_n, // Power good, low = good
  output logic stat_o, // State pin level
  output logic stat_oe, // State pin pull-down enable
  output logic host_int_n // Interrupt, low pulse
);
  import csf_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_CHG, ST_DONE, ST_SUSP} csf_st_t;
  localparam int NP = $bits(csf_pin_t);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [NP-1:0] s1_r, s2_r, s3_r; // Three-stage chain
  csf_pin_t p; // Filtered inputs
  // A change is accepted only when stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      p <= '0;
    end else begin
      s1_r <= pins_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        p <= s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave and configuration
  logic [7:0] src_r, pwr_r, cur_r, trm_r, thr_r, msc_r; // Config regs
  logic host_mode_r; // Host mode after first write
  logic ack_r; // One wait state then accept
  logic acc_rd, acc_wr; // Accepted access
  logic [7:0] fault_lat_r; // Latched fault view
  logic [7:0] fault_live; // Live fault view
  logic [7:0] status; // System status view
  logic hw_set_hz, hw_clr_hz; // Hardware highz controls
  logic [7:0] wdat; // Low byte of write data

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign acc_rd = avs_read & ack_r;
  assign acc_wr = avs_write & ack_r & avs_byteenable[0];
  assign wdat = avs_writedata[7:0];

  // Ack toggles so every access sees exactly one wait cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // Read data is registered in the wait cycle, one edge before the accepting edge; unmapped reads zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (avs_read & ~ack_r) begin
      case (avs_address)
        OFS_SRC: avs_readdata <= {24'h0, src_r};
        OFS_PWR: avs_readdata <= {24'h0, pwr_r};
        OFS_CUR: avs_readdata <= {24'h0, cur_r};
        OFS_TRM: avs_readdata <= {24'h0, trm_r};
        OFS_THR: avs_readdata <= {24'h0, thr_r};
        OFS_MSC: avs_readdata <= {24'h0, msc_r};
        OFS_STS: avs_readdata <= {24'h0, status};
        OFS_FLT: avs_readdata <= {24'h0, fault_lat_r};
        default: avs_readdata <= '0;
      endcase
    end
  end

  // Configuration writes; unmapped writes are dropped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r <= RST_PWR;
      cur_r <= RST_CUR;
      trm_r <= RST_TRM;
      thr_r <= RST_THR;
      msc_r <= RST_MSC;
    end else if (acc_wr) begin
      case (avs_address)
        OFS_PWR: pwr_r <= wdat;
        OFS_CUR: cur_r <= wdat;
        OFS_TRM: trm_r <= wdat;
        OFS_THR: thr_r <= wdat;
        OFS_MSC: msc_r <= wdat;
        default: ;
      endcase
    end
  end

  // Highz bit: hardware set beats a software clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_r <= RST_SRC;
    end else begin
      if (acc_wr && avs_address == OFS_SRC) begin
        src_r <= wdat;
      end
      if (hw_set_hz) begin
        src_r[B_HIGHZ] <= 1'b1;
      end else if (hw_clr_hz) begin
        src_r[B_HIGHZ] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_mode_r <= 1'b0;
    end else if (avs_write & ack_r) begin
      host_mode_r <= 1'b1;
    end
  end

  assign thermal_limit_sel = thr_r[1:0];

  ////////////////////////////////////////////////////////////////////////
  // Charge cycle
  csf_st_t st_r; // Charge state
  logic tmr_flt_r; // Safety timer expired
  logic highz; // Input stage parked
  logic suspend; // Fault suspends charging
  logic allowed; // Charging may run
  logic term_ok; // Termination condition met
  logic regul; // Any regulation loop active

  assign highz = src_r[B_HIGHZ];
  assign regul = p.in_dpm | p.therm_reg;
  assign suspend = p.input_overvoltage | p.system_overvoltage |
                   p.therm_shut | tmr_flt_r;
  assign allowed = (pwr_r[5:4] == CFG_CHG) & ~p.ce_n & ~highz;
  assign term_ok = trm_r[B_TERM_EN] & ~regul & p.bat_above_rechg &
                   p.ichg_below_term;

  // Charger states; done re-enters charging below recharge threshold
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_OFF;
    end else begin
      case (st_r)
        ST_OFF: begin
          if (allowed && suspend) begin
            st_r <= ST_SUSP;
          end else if (allowed) begin
            st_r <= ST_CHG;
          end
        end
        ST_CHG: begin
          if (!allowed) begin
            st_r <= ST_OFF;
          end else if (suspend) begin
            st_r <= ST_SUSP;
          end else if (term_ok) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!allowed) begin
            st_r <= ST_OFF;
          end else if (!p.bat_above_rechg) begin
            st_r <= ST_CHG;
          end
        end
        ST_SUSP: begin
          if (!allowed || !suspend) begin
            st_r <= ST_OFF;
          end
        end
        default: st_r <= ST_OFF;
      endcase
    end
  end

  // Switch off after termination, converter keeps running
  // Shutdown and overvoltage stop the buck at once
  assign pwr_o.battery_path_switch = (st_r == ST_CHG);
  assign pwr_o.buck_run = ~highz & ~p.input_overvoltage &
                          ~p.system_overvoltage & ~p.therm_shut &
                          ~p.boost_mode;

  assign status = {2'b00,
                   (st_r == ST_DONE) ? PH_DONE :
                   (st_r == ST_CHG) ? (p.bat_low ? PH_PRE : PH_FAST) :
                   PH_OFF,
                   p.in_dpm, 1'b0, p.therm_reg, 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // Time base and safety timers
  logic [23:0] pre_r; // Half-second prescaler
  logic hs_tick; // Half-second strobe
  logic [1:0] ph_r; // Half-second phase
  logic sec_tick; // Full-rate second strobe
  logic slow; // Half-rate counting active
  logic adv; // Timer advances this cycle
  logic [16:0] tsec_r; // Safety timer seconds
  logic [16:0] usb_r; // USB100 timer seconds
  logic [16:0] limit; // Selected duration
  logic restart; // Safety timer restart
  logic ce_low_seen_r; // Charge enable pin went low
  logic [1:0] cfg_prev_r; // Previous charge config
  logic ten_prev_r; // Previous timer enable
  logic new_cycle; // Entry into charging

  assign hs_tick = (pre_r == 24'(HALF_SEC - 1));
  assign sec_tick = hs_tick & ph_r[0];
  // Half rate when regulating or forced, unless disabled
  assign slow = msc_r[B_HALF_EN] & (regul | cur_r[B_FORCE]);
  assign adv = sec_tick & (~slow | ph_r[1]);
  assign new_cycle = (st_r != ST_CHG) & allowed & ~suspend &
                     (st_r == ST_OFF || !p.bat_above_rechg);

  // Prescaler and half-second phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= '0;
      ph_r <= '0;
    end else begin
      pre_r <= hs_tick ? '0 : pre_r + 24'd1;
      if (hs_tick) begin
        ph_r <= ph_r + 2'd1;
      end
    end
  end

  // Low battery and /mode select the duration
  always_comb begin
    if (p.bat_low) begin
      limit = T_LOWBAT_S;
    end else if (!host_mode_r) begin
      limit = T_DEFAULT_S;
    end else begin
      case (trm_r[2:1])
        2'd0: limit = T_SEL0_S;
        2'd1: limit = T_SEL1_S;
        2'd2: limit = T_SEL2_S;
        default: limit = T_SEL3_S;
      endcase
    end
  end

  // Edge trackers for restart sources
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ce_low_seen_r <= 1'b0;
      cfg_prev_r <= RST_PWR[5:4];
      ten_prev_r <= RST_TRM[B_TMR_EN];
    end else begin
      cfg_prev_r <= pwr_r[5:4];
      ten_prev_r <= trm_r[B_TMR_EN];
      if (!p.ce_n) begin
        ce_low_seen_r <= 1'b1;
      end else if (restart) begin
        ce_low_seen_r <= 1'b0;
      end
    end
  end

  assign restart = new_cycle | (p.ce_n & ce_low_seen_r) |
                   (cfg_prev_r == CFG_OFF && pwr_r[5:4] == CFG_CHG) |
                   (~ten_prev_r & trm_r[B_TMR_EN]);

  // Safety timer runs only while charging with the timer enabled
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tsec_r <= '0;
      tmr_flt_r <= 1'b0;
    end else if (restart || !trm_r[B_TMR_EN]) begin
      tsec_r <= '0;
      tmr_flt_r <= 1'b0;
    end else if (st_r == ST_CHG && adv) begin
      if (tsec_r + 17'd1 >= limit) begin
        tmr_flt_r <= 1'b1;
      end
      tsec_r <= tsec_r + 17'd1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      usb_r <= '0;
    end else if (host_mode_r || !p.usb100 || st_r != ST_CHG) begin
      usb_r <= '0;
    end else if (sec_tick && usb_r != T_USB_S) begin
      usb_r <= usb_r + 17'd1;
    end
  end

  logic tmr_rise; // Expiry event
  logic tmr_prev_r; // Previous expiry flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_prev_r <= 1'b0;
    end else begin
      tmr_prev_r <= tmr_flt_r;
    end
  end
  assign tmr_rise = tmr_flt_r & ~tmr_prev_r;
  // Default expiry parks input; USB end parks input
  assign hw_set_hz = (tmr_rise & ~host_mode_r) |
                     (usb_r == T_USB_S && st_r == ST_CHG);
  // Host expiry keeps buck supplying system
  assign hw_clr_hz = tmr_rise & host_mode_r;

  ////////////////////////////////////////////////////////////////////////
  // Boost protection
  logic boost_trip_r; // Boost overvoltage seen
  // Trip holds until boost is released
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      boost_trip_r <= 1'b0;
    end else if (p.boost_mode && p.boost_ov) begin
      boost_trip_r <= 1'b1;
    end else if (!p.boost_mode) begin
      boost_trip_r <= 1'b0;
    end
  end
  assign pwr_o.boost_run = p.boost_mode & ~p.boost_ov & ~boost_trip_r;

  ////////////////////////////////////////////////////////////////////////
  // Fault latch and interrupt
  logic [7:0] live_prev_r; // Previous live faults
  logic pend_r; // Fault reported, not yet read
  logic flt_rd; // Accepted fault register read
  logic new_flt; // Fresh fault bit
  logic [1:0] fcode; // Live fault code

  assign fcode = p.therm_shut ? FC_TSHUT : tmr_flt_r ? FC_TIMER :
                 p.input_overvoltage ? FC_INOV : FC_NONE;
  assign fault_live = {~host_mode_r, boost_trip_r, fcode, 4'h0};
  assign flt_rd = acc_rd & (avs_address == OFS_FLT);
  assign new_flt = |(fault_live[6:4] & ~live_prev_r[6:4]);

  // Sticky latch; a read reloads it with the live view
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_lat_r <= 8'h80;
      live_prev_r <= '0;
      pend_r <= 1'b0;
    end else begin
      live_prev_r <= fault_live;
      if (flt_rd) begin
        fault_lat_r <= fault_live;
      end else begin
        fault_lat_r <= {fault_live[7], fault_lat_r[6:0] | fault_live[6:0]};
      end
      if (new_flt) begin
        pend_r <= 1'b1;
      end else if (flt_rd) begin
        pend_r <= 1'b0;
      end
    end
  end

  logic good; // Input good
  logic good_prev_r; // Previous input good
  logic id_prev_r; // Previous source identified
  logic done_prev_r; // Previous done state
  logic int_ev; // Any interrupt event
  logic [12:0] int_cnt_r; // Pulse width counter

  assign good = p.vbus_uvlo_ok & p.vbus_above_bat &
                ~p.input_overvoltage & p.vbus_load_ok;
  assign input_good_pin_n = ~good;
  assign int_ev = (p.src_ident & ~id_prev_r) | (good ^ good_prev_r) |
                  ((st_r == ST_DONE) & ~done_prev_r) |
                  (new_flt & ~pend_r);

  // Pulse restarts on a new event; width is INT_CYC cycles
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      good_prev_r <= 1'b0;
      id_prev_r <= 1'b0;
      done_prev_r <= 1'b0;
      int_cnt_r <= '0;
    end else begin
      good_prev_r <= good;
      id_prev_r <= p.src_ident;
      done_prev_r <= (st_r == ST_DONE);
      if (int_ev) begin
        int_cnt_r <= 13'(INT_CYC);
      end else if (int_cnt_r != 13'd0) begin
        int_cnt_r <= int_cnt_r - 13'd1;
      end
    end
  end
  assign host_int_n = (int_cnt_r == 13'd0);

  ////////////////////////////////////////////////////////////////////////
  // State pin: open drain, pull low while charging
  logic stat_high; // Pin released
  // Blink in suspend; early done releases pin
  assign stat_high = (st_r == ST_SUSP) ? ph_r[0] :
                     (st_r == ST_CHG) ?
                     (trm_r[B_EARLY] & p.ichg_below_800) : 1'b1;
  assign stat_o = 1'b0;
  assign stat_oe = ~stat_high;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_term_off;
    @(posedge core_clk) disable iff (!arst_n)
    st_r == ST_CHG && allowed && !suspend && term_ok
      |=> !pwr_o.battery_path_switch && st_r == ST_DONE;
  endproperty
  a_term_off: assert property (p_term_off) else $error("no end");
  property p_done_int;
    @(posedge core_clk) disable iff (!arst_n)
    $rose(st_r == ST_DONE) |-> ##1 !host_int_n && status[5:4] == PH_DONE;
  endproperty
  a_done_int: assert property (p_done_int) else $error("done irq");
  property p_no_term_reg;
    @(posedge core_clk) disable iff (!arst_n)
    st_r == ST_CHG && regul |=> st_r != ST_DONE;
  endproperty
  a_no_term_reg: assert property (p_no_term_reg) else $error("term");
  property p_early;
    @(posedge core_clk) disable iff (!arst_n)
    st_r == ST_CHG && trm_r[B_EARLY] && p.ichg_below_800 |-> !stat_oe;
  endproperty
  a_early: assert property (p_early) else $error("early done");
  property p_def_hz;
    @(posedge core_clk) disable iff (!arst_n)
    tmr_rise && !host_mode_r |=> highz;
  endproperty
  a_def_hz: assert property (p_def_hz) else $error("highz set");
  property p_host_hz;
    @(posedge core_clk) disable iff (!arst_n)
    tmr_rise && host_mode_r && !(usb_r == T_USB_S) |=> !highz;
  endproperty
  a_host_hz: assert property (p_host_hz) else $error("highz clr");
  property p_tmr_code;
    @(posedge core_clk) disable iff (!arst_n)
    $rose(tmr_flt_r) && !p.therm_shut |-> fault_live[5:4] == FC_TIMER
      ##1 fault_lat_r[5:4] != FC_NONE;
  endproperty
  a_tmr_code: assert property (p_tmr_code) else $error("timer");
  property p_tshut;
    @(posedge core_clk) disable iff (!arst_n)
    p.therm_shut |-> !pwr_o.buck_run ##1 fault_lat_r[5];
  endproperty
  a_tshut: assert property (p_tshut) else $error("shutdown");
  property p_boost;
    @(posedge core_clk) disable iff (!arst_n)
    p.boost_mode && p.boost_ov |=> !pwr_o.boost_run ##1 fault_lat_r[6];
  endproperty
  a_boost: assert property (p_boost) else $error("boost ov");
  property p_quiet;
    @(posedge core_clk) disable iff (!arst_n)
    pend_r && !flt_rd && host_int_n && !(good ^ good_prev_r) &&
      !(p.src_ident & ~id_prev_r) && st_r != ST_DONE |=> host_int_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("extra irq");
  c_done: cover property (@(posedge core_clk) $rose(st_r == ST_DONE));
  c_expire: cover property (@(posedge core_clk) tmr_rise);
  c_fltrd: cover property (@(posedge core_clk) flt_rd ##3 flt_rd);
  c_susp: cover property (@(posedge core_clk) st_r == ST_SUSP);
endmodule
`default_nettype wire

// file: shared/csf_pkg.sv
// Constants and carrier types for the charge supervision fault logic
package csf_pkg;
  // Clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYC = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int INT_PULSE_US = 256;
  localparam int INT_PULSE_CYC = CLK_HZ / 1_000_000 * INT_PULSE_US;
  // Safety timer durations in seconds
  localparam logic [16:0] T_DEFAULT_S = 17'd18000; // 5 hours
  localparam logic [16:0] T_LOWBAT_S = 17'd3600; // 1 hour
  localparam logic [16:0] T_USB_S = 17'd2700; // 45 minutes
  localparam logic [16:0] T_SEL0_S = 17'd18000; // 5 hours
  localparam logic [16:0] T_SEL1_S = 17'd28800; // 8 hours
  localparam logic [16:0] T_SEL2_S = 17'd43200; // 12 hours
  localparam logic [16:0] T_SEL3_S = 17'd72000; // 20 hours
  // Register byte offsets
  localparam logic [5:0] OFS_SRC = 6'h00; // input_source_control
  localparam logic [5:0] OFS_PWR = 6'h04; // power_on_config
  localparam logic [5:0] OFS_CUR = 6'h08; // charge_current_control
  localparam logic [5:0] OFS_TRM = 6'h14; // term_timer_control
  localparam logic [5:0] OFS_THR = 6'h18; // thermal_reg_control
  localparam logic [5:0] OFS_MSC = 6'h1c; // misc_operation_control
  localparam logic [5:0] OFS_STS = 6'h20; // system_status
  localparam logic [5:0] OFS_FLT = 6'h24; // fault_latch
  // Reset values
  localparam logic [7:0] RST_SRC = 8'h30;
  localparam logic [7:0] RST_PWR = 8'h1b;
  localparam logic [7:0] RST_CUR = 8'h60;
  localparam logic [7:0] RST_TRM = 8'h9a;
  localparam logic [7:0] RST_THR = 8'h03;
  localparam logic [7:0] RST_MSC = 8'h40;
  // Field positions
  localparam int B_HIGHZ = 7; // input_source_control
  localparam int B_FORCE = 0; // charge_current_control
  localparam int B_TERM_EN = 7; // term_timer_control
  localparam int B_EARLY = 6;
  localparam int B_TMR_EN = 3;
  localparam int B_HALF_EN = 6; // misc_operation_control
  // Codes
  localparam logic [1:0] PH_OFF = 2'h0;
  localparam logic [1:0] PH_PRE = 2'h1;
  localparam logic [1:0] PH_FAST = 2'h2;
  localparam logic [1:0] PH_DONE = 2'h3;
  localparam logic [1:0] FC_NONE = 2'h0;
  localparam logic [1:0] FC_INOV = 2'h1;
  localparam logic [1:0] FC_TSHUT = 2'h2;
  localparam logic [1:0] FC_TIMER = 2'h3;
  localparam logic [1:0] CFG_OFF = 2'h0;
  localparam logic [1:0] CFG_CHG = 2'h1;
  // Analog comparator and pin inputs
  typedef struct packed {
    logic bat_above_rechg; // Battery above recharge threshold
    logic ichg_below_term; // Charge current below termination
    logic ichg_below_800; // Charge current below 800 mA
    logic in_dpm; // Input current or voltage regulation
    logic therm_reg; // Junction above selected limit
    logic therm_shut; // Thermal shutdown
    logic input_overvoltage; // Input above 18 V
    logic system_overvoltage; // System rail too high
    logic boost_mode; // Boost operation requested
    logic boost_ov; // Boost output above 5.3 V
    logic bat_low; // Battery below battery_low_threshold
    logic ce_n; // Charge enable pin, low enables
    logic usb100; // Source is a 100 mA USB port
    logic src_ident; // Source type identified
    logic vbus_uvlo_ok; // Input above undervoltage lockout
    logic vbus_above_bat; // Input above battery
    logic vbus_load_ok; // Input above 3.8 V at 30 mA
  } csf_pin_t;
  // Power stage controls
  typedef struct packed {
    logic buck_run; // Buck converter switching
    logic boost_run; // Boost converter switching
    logic battery_path_switch; // Battery switch on for charging
  } csf_pwr_t;
endpackage
